// ===== inc/racs_params.svh
`ifndef RACS_PARAMS_SVH
`define RACS_PARAMS_SVH

// Order command codes.
`define RACS_CMD_RD_IO 8'h00
`define RACS_CMD_WR_IO 8'h01
`define RACS_CMD_UPD_IO 8'h02
`define RACS_CMD_OR_IO 8'h03
`define RACS_CMD_AND_IO 8'h04
`define RACS_CMD_XOR_IO 8'h05
`define RACS_CMD_RD_MEM 8'h06
`define RACS_CMD_WR_MEM 8'h07
`define RACS_CMD_DNLOAD 8'h08
`define RACS_CMD_UPLOAD 8'h09
`define RACS_CMD_GET_FN 8'h0A
`define RACS_CMD_PROTECT 8'h0B
`define RACS_CMD_RESET 8'h0C

// Reply status codes.
`define RACS_ST_OK 8'h00
`define RACS_ST_BAD_CMD 8'h01
`define RACS_ST_BAD_CNT 8'h02
`define RACS_ST_PROT 8'h03
`define RACS_ST_BAD_ADDR 8'h04

// Locations per order and sizes.
`define RACS_MAX_LOC 6
`define RACS_FN_COUNT 8
`define RACS_RAM_DEPTH 192

// Jumper field positions.
`define RACS_JMP_MODE_BIT 0
`define RACS_JMP_RATE_BIT 1
`define RACS_JMP_NODE_LSB 2
`define RACS_JMP_NODE_MSB 9

// Power-up test pattern and timing.
`define RACS_DIAG_PATTERN 8'hA5
`define RACS_CLK_MHZ 250
`define RACS_DIAG_SHOW_US 1000

`endif

// ===== inc/racs_pkg.sv
package racs_pkg;

   typedef enum logic [3:0] {
      S_DIAG_WR = 4'h0,
      S_DIAG_RD = 4'h1,
      S_DIAG_WT = 4'h2,
      S_DIAG_CHK = 4'h3,
      S_SHOW = 4'h4,
      S_IDLE = 4'h5,
      S_ISSUE = 4'h6,
      S_WAIT = 4'h7,
      S_CAP = 4'h8,
      S_NEXT = 4'h9,
      S_REPLY = 4'hA
   } racs_state_e;

   typedef enum logic [1:0] {
      RATE_2400K = 2'h0,
      RATE_375K = 2'h1,
      RATE_62K5 = 2'h2
   } racs_rate_e;

   typedef struct packed {
      logic [7:0] cmd;
      logic [2:0] cnt;
      logic [5:0][15:0] addr;
      logic [5:0][7:0] data;
   } racs_order_s;

   typedef struct packed {
      logic [7:0] status;
      logic [3:0] cnt;
      logic [7:0][7:0] data;
   } racs_reply_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic mem;
      logic [15:0] addr;
      logic [7:0] wdata;
   } racs_ext_s;

   typedef struct packed {
      logic self_clocked;
      racs_rate_e rate;
      logic [7:0] node;
   } racs_cfg_s;

endpackage : racs_pkg

// ===== hw/racs_ram.sv
`timescale 1ns/1ns
module racs_ram #(
   parameter int DEPTH = 192,
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic clk_in, // Clock.
   input wire logic rst_n_in, // Synchronous reset, active low.
   input wire logic we_in, // Write strobe.
   input wire logic re_in, // Read strobe.
   input wire logic [AW-1:0] addr_in, // Byte address.
   input wire logic [DW-1:0] wdata_in, // Write data.
   output logic [DW-1:0] rdata_out // Read data, one cycle after re_in.
);
   logic [DW-1:0] mem_q [DEPTH];
   logic [DW-1:0] rdata_d;

   always_comb begin
      rdata_d = rdata_out;
      if (re_in) begin
         rdata_d = mem_q[addr_in];
      end
   end

   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem_q[addr_in] <= wdata_in;
      end
      if (!rst_n_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= rdata_d;
      end
   end
endmodule : racs_ram

// ===== hw/racs_engine.sv
// Notes on behaviour
// R01: Read-I/O reads each addressed external I/O location and returns the value.
// R02: Write-I/O stores the supplied byte into each addressed external I/O location.
// R03: Update-I/O writes the byte, reads the location back, returns the read value.
// R04: OR, AND, XOR I/O combine data with location content and return result.
// R05: Read-internal-memory fetches on-chip data RAM locations and returns them.
// R06: Write-internal-memory stores supplied data into on-chip data RAM locations.
// R07: Download writes supplied data into external memory from the starting location.
// R08: Upload reads external memory from the starting location and returns the data.
// R09: Get-functions replies with the eight function identification codes.
// R10: Protect order suspends or resumes the remote access service.
// R11: Reset-device order returns operating state to its post-initialization condition.
// R12: An order names one to six locations; every named location is acted on.
// R13: Internal memory addresses given must lie within the 192-byte data RAM.
// R14: Bus mode, rate and node address come from jumpers.
// R15: Power-up diagnostics signal controller or external bus failure on the LEDs.
// R16: After diagnostics the LEDs are released to user control.
// R17: An unrecognised command code yields an error status in the reply.
`timescale 1ns/1ns
`include "racs_params.svh"
module racs_engine #(
   parameter int unsigned DIAG_SHOW_CYC = `RACS_DIAG_SHOW_US * `RACS_CLK_MHZ
) (
   input wire logic clk_in, // 250 MHz clock.
   input wire logic rst_n_in, // Synchronous reset, active low.
   input wire logic order_valid_in, // Order offered.
   input wire racs_pkg::racs_order_s order_in, // Order contents.
   output logic order_ready_out, // Engine idle and able to take an order.
   output logic reply_valid_out, // One-cycle reply strobe.
   output racs_pkg::racs_reply_s reply_out, // Reply, held until the next order.
   output racs_pkg::racs_ext_s ext_out, // External I/O and memory request.
   input wire logic [7:0] ext_rdata_in, // Read data, one cycle after ext_out.rd.
   input wire logic [7:0][7:0] fn_id_in, // Function codes of running tasks.
   input wire logic [9:0] jumper_in, // Jumper pins.
   input wire logic ext_fault_in, // External bus fault pin.
   input wire logic [1:0] user_led_in, // User LED levels after diagnostics.
   output logic [1:0] led_out, // Indicator LEDs, high is lit.
   output racs_pkg::racs_cfg_s cfg_out // Bus mode, rate and node address.
);
   import racs_pkg::*;

   racs_state_e st_q, st_d;
   racs_order_s ord_q, ord_d;
   racs_reply_s rpl_d;
   racs_ext_s ext_d;
   racs_cfg_s cfg_d;
   logic [2:0] idx_q, idx_d;
   logic ph_q, ph_d;
   logic prot_q, prot_d;
   logic rdy_d, rvld_d;
   logic [1:0] led_d;
   logic [31:0] show_q, show_d;
   logic ram_we_q, ram_we_d, ram_re_q, ram_re_d;
   logic [7:0] ram_a_q, ram_a_d, ram_wd_q, ram_wd_d, ram_rd;
   logic [9:0] jmp1_q, jmp2_q;
   logic flt1_q, flt2_q;
   logic [15:0] cur_addr;
   logic [7:0] cur_data, rd_val, comb_val;
   logic blk_op, int_op;

   racs_ram #(
      .DEPTH(`RACS_RAM_DEPTH),
      .AW(8),
      .DW(8)
   ) u_ram (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .we_in(ram_we_q),
      .re_in(ram_re_q),
      .addr_in(ram_a_q),
      .wdata_in(ram_wd_q),
      .rdata_out(ram_rd)
   );

   // Pins from outside the clock domain pass two flip-flops first.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         jmp1_q <= '0;
         jmp2_q <= '0;
         flt1_q <= 1'b0;
         flt2_q <= 1'b0;
      end else begin
         jmp1_q <= jumper_in;
         jmp2_q <= jmp1_q;
         flt1_q <= ext_fault_in;
         flt2_q <= flt1_q;
      end
   end

   always_comb begin
      blk_op = (ord_q.cmd == `RACS_CMD_DNLOAD) || (ord_q.cmd == `RACS_CMD_UPLOAD);
      int_op = (ord_q.cmd == `RACS_CMD_RD_MEM) || (ord_q.cmd == `RACS_CMD_WR_MEM);
      // R07 block start
      cur_addr = blk_op ? ord_q.addr[0] + 16'(idx_q) : ord_q.addr[idx_q];
      cur_data = ord_q.data[idx_q];
      rd_val = int_op ? ram_rd : ext_rdata_in;
      // R04 logic combine
      case (ord_q.cmd)
         `RACS_CMD_OR_IO: comb_val = rd_val | cur_data;
         `RACS_CMD_AND_IO: comb_val = rd_val & cur_data;
         `RACS_CMD_XOR_IO: comb_val = rd_val ^ cur_data;
         default: comb_val = rd_val;
      endcase
   end

   always_comb begin
      st_d = st_q;
      ord_d = ord_q;
      rpl_d = reply_out;
      ext_d = '0;
      cfg_d = cfg_out;
      idx_d = idx_q;
      ph_d = ph_q;
      prot_d = prot_q;
      rvld_d = 1'b0;
      led_d = led_out;
      show_d = show_q;
      ram_we_d = 1'b0;
      ram_re_d = 1'b0;
      ram_a_d = ram_a_q;
      ram_wd_d = ram_wd_q;
      // R16 LEDs released
      if (st_q inside {S_IDLE, S_ISSUE, S_WAIT, S_CAP, S_NEXT, S_REPLY}) begin
         led_d = user_led_in;
      end
      case (st_q)
         S_DIAG_WR: begin
            led_d = 2'h3;
            ram_we_d = 1'b1;
            ram_a_d = 8'h00;
            ram_wd_d = `RACS_DIAG_PATTERN;
            st_d = S_DIAG_RD;
         end
         S_DIAG_RD: begin
            ram_re_d = 1'b1;
            st_d = S_DIAG_WT;
         end
         S_DIAG_WT: begin
            st_d = S_DIAG_CHK;
         end
         S_DIAG_CHK: begin
            // R15 failure shown
            led_d = {ram_rd != `RACS_DIAG_PATTERN, flt2_q};
            // R14 jumper capture
            cfg_d.self_clocked = jmp2_q[`RACS_JMP_MODE_BIT];
            cfg_d.rate = !jmp2_q[`RACS_JMP_MODE_BIT] ? RATE_2400K :
                         jmp2_q[`RACS_JMP_RATE_BIT] ? RATE_62K5 : RATE_375K;
            cfg_d.node = jmp2_q[`RACS_JMP_NODE_MSB:`RACS_JMP_NODE_LSB];
            show_d = '0;
            st_d = S_SHOW;
         end
         S_SHOW: begin
            show_d = show_q + 32'h1;
            if (show_q >= DIAG_SHOW_CYC - 1) begin
               st_d = S_IDLE;
            end
         end
         S_IDLE: begin
            if (order_valid_in && order_ready_out) begin
               ord_d = order_in;
               idx_d = '0;
               ph_d = 1'b0;
               rpl_d = '0;
               rpl_d.status = `RACS_ST_OK;
               st_d = S_REPLY;
               case (order_in.cmd)
                  // R11 reset device
                  `RACS_CMD_RESET: prot_d = 1'b0;
                  // R10 protect switch
                  `RACS_CMD_PROTECT: prot_d = order_in.data[0][0];
                  `RACS_CMD_GET_FN: begin
                     if (prot_q) begin
                        rpl_d.status = `RACS_ST_PROT;
                     end else begin
                        // R09 function list
                        rpl_d.data = fn_id_in;
                        rpl_d.cnt = 4'(`RACS_FN_COUNT);
                     end
                  end
                  `RACS_CMD_RD_IO, `RACS_CMD_WR_IO, `RACS_CMD_UPD_IO, `RACS_CMD_OR_IO,
                  `RACS_CMD_AND_IO, `RACS_CMD_XOR_IO, `RACS_CMD_RD_MEM, `RACS_CMD_WR_MEM,
                  `RACS_CMD_DNLOAD, `RACS_CMD_UPLOAD: begin
                     // R12 location count
                     if (order_in.cnt == 3'h0 || order_in.cnt > 3'(`RACS_MAX_LOC)) begin
                        rpl_d.status = `RACS_ST_BAD_CNT;
                     // R10 service suspended
                     end else if (prot_q) begin
                        rpl_d.status = `RACS_ST_PROT;
                     end else begin
                        rpl_d.cnt = {1'b0, order_in.cnt};
                        st_d = S_ISSUE;
                     end
                  end
                  // R17 unknown command
                  default: rpl_d.status = `RACS_ST_BAD_CMD;
               endcase
            end
         end
         S_ISSUE: begin
            ext_d.addr = cur_addr;
            ext_d.mem = blk_op;
            ram_a_d = cur_addr[7:0];
            st_d = S_WAIT;
            case (ord_q.cmd)
               // R02 write I/O
               `RACS_CMD_WR_IO: begin
                  ext_d.wr = 1'b1;
                  ext_d.wdata = cur_data;
                  st_d = S_NEXT;
               end
               // R03 write then read
               `RACS_CMD_UPD_IO: begin
                  ext_d.wr = !ph_q;
                  ext_d.rd = ph_q;
                  ext_d.wdata = cur_data;
                  ph_d = 1'b1;
                  st_d = ph_q ? S_WAIT : S_ISSUE;
               end
               `RACS_CMD_OR_IO, `RACS_CMD_AND_IO, `RACS_CMD_XOR_IO: begin
                  ext_d.rd = !ph_q;
                  ext_d.wr = ph_q;
                  ext_d.wdata = reply_out.data[idx_q];
                  st_d = ph_q ? S_NEXT : S_WAIT;
               end
               `RACS_CMD_RD_MEM, `RACS_CMD_WR_MEM: begin
                  // R13 address range
                  if (cur_addr >= 16'(`RACS_RAM_DEPTH)) begin
                     rpl_d.status = `RACS_ST_BAD_ADDR;
                     st_d = S_NEXT;
                  // R06 internal write
                  end else if (ord_q.cmd == `RACS_CMD_WR_MEM) begin
                     ram_we_d = 1'b1;
                     ram_wd_d = cur_data;
                     st_d = S_NEXT;
                  // R05 internal read
                  end else begin
                     ram_re_d = 1'b1;
                  end
               end
               // R07 download write
               `RACS_CMD_DNLOAD: begin
                  ext_d.wr = 1'b1;
                  ext_d.wdata = cur_data;
                  st_d = S_NEXT;
               end
               // R01 R08 reads
               default: ext_d.rd = 1'b1;
            endcase
         end
         S_WAIT: begin
            st_d = S_CAP;
         end
         S_CAP: begin
            // R01 R03 R04 R05 R08 result
            rpl_d.data[idx_q] = comb_val;
            if (ord_q.cmd inside {`RACS_CMD_OR_IO, `RACS_CMD_AND_IO, `RACS_CMD_XOR_IO} && !ph_q) begin
               ph_d = 1'b1;
               st_d = S_ISSUE;
            end else begin
               st_d = S_NEXT;
            end
         end
         S_NEXT: begin
            // R12 every location
            if (idx_q == ord_q.cnt - 3'h1) begin
               st_d = S_REPLY;
            end else begin
               idx_d = idx_q + 3'h1;
               ph_d = 1'b0;
               st_d = S_ISSUE;
            end
         end
         S_REPLY: begin
            rvld_d = 1'b1;
            st_d = S_IDLE;
         end
         default: st_d = S_IDLE;
      endcase
      rdy_d = (st_d == S_IDLE) && !(st_q == S_IDLE && order_valid_in && order_ready_out);
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_q <= S_DIAG_WR;
         ord_q <= '0;
         reply_out <= '0;
         reply_valid_out <= 1'b0;
         order_ready_out <= 1'b0;
         ext_out <= '0;
         cfg_out <= '0;
         idx_q <= '0;
         ph_q <= 1'b0;
         prot_q <= 1'b0;
         led_out <= 2'h3;
         show_q <= '0;
         ram_we_q <= 1'b0;
         ram_re_q <= 1'b0;
         ram_a_q <= '0;
         ram_wd_q <= '0;
      end else begin
         st_q <= st_d;
         ord_q <= ord_d;
         reply_out <= rpl_d;
         reply_valid_out <= rvld_d;
         order_ready_out <= rdy_d;
         ext_out <= ext_d;
         cfg_out <= cfg_d;
         idx_q <= idx_d;
         ph_q <= ph_d;
         prot_q <= prot_d;
         led_out <= led_d;
         show_q <= show_d;
         ram_we_q <= ram_we_d;
         ram_re_q <= ram_re_d;
         ram_a_q <= ram_a_d;
         ram_wd_q <= ram_wd_d;
      end
   end
endmodule : racs_engine

// ===== bench/racs_engine_properties.sv
`timescale 1ns/1ns
`include "racs_params.svh"
module racs_engine_properties (
   input wire logic clk_in, // Clock.
   input wire logic rst_n_in, // Reset, active low.
   input wire logic order_valid_in, // Order offered.
   input wire racs_pkg::racs_order_s order_in, // Order contents.
   input wire logic order_ready_out, // Engine idle.
   input wire logic reply_valid_out, // Reply strobe.
   input wire racs_pkg::racs_reply_s reply_out, // Reply contents.
   input wire racs_pkg::racs_ext_s ext_out, // External request.
   input wire logic [9:0] jumper_in, // Jumper pins.
   input wire logic [1:0] user_led_in, // User LED levels.
   input wire logic [1:0] led_out, // Indicator LEDs.
   input wire racs_pkg::racs_cfg_s cfg_out // Captured settings.
);
   import racs_pkg::*;
   logic take;
   assign take = order_valid_in && order_ready_out;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   AST_RD_PULSE: assert property (ext_out.rd |=> !ext_out.rd)
      else $error("external read strobe longer than one cycle");
   AST_EXT_IDLE: assert property (order_ready_out |-> !ext_out.rd && !ext_out.wr)
      else $error("external strobe while idle");
   AST_MEM_QUIET: assert property (take && order_in.cmd == `RACS_CMD_RD_MEM |=>
      (!ext_out.rd && !ext_out.wr) [*3]) else $error("external activity on internal read");
   AST_GETFN: assert property (take && order_in.cmd == `RACS_CMD_GET_FN |-> ##[1:3]
      reply_valid_out && (reply_out.cnt == 4'h8 || reply_out.status == `RACS_ST_PROT))
      else $error("function list reply wrong");
   AST_PROT: assert property (take && order_in.cmd == `RACS_CMD_PROTECT |-> ##[1:3]
      reply_valid_out && reply_out.status == `RACS_ST_OK) else $error("protect reply missing");
   AST_BAD_CNT: assert property (take && order_in.cmd <= `RACS_CMD_UPLOAD && order_in.cnt == 3'h0
      |-> ##[1:3] reply_valid_out && reply_out.status inside {`RACS_ST_BAD_CNT, `RACS_ST_PROT})
      else $error("zero count not refused");
   AST_CFG: assert property (order_ready_out |-> cfg_out.node == jumper_in[9:2] &&
      cfg_out.self_clocked == jumper_in[0]) else $error("settings differ from jumpers");
   AST_LED: assert property (order_ready_out && $past(order_ready_out, 2) |->
      led_out == $past(user_led_in)) else $error("LEDs do not follow user levels");
   AST_BAD_CMD: assert property (take && order_in.cmd > `RACS_CMD_RESET |-> ##[1:3]
      reply_valid_out && reply_out.status == `RACS_ST_BAD_CMD) else $error("unknown command not refused");
endmodule : racs_engine_properties

bind racs_engine racs_engine_properties i_racs_engine_properties (.clk_in, .rst_n_in, .order_valid_in,
   .order_in, .order_ready_out, .reply_valid_out, .reply_out, .ext_out, .jumper_in, .user_led_in,
   .led_out, .cfg_out);

// ===== bench/racs_ext_model.sv
`timescale 1ns/1ns
module racs_ext_model (
   input wire logic clk_in, // Clock.
   input wire racs_pkg::racs_ext_s ext_in, // Request from the engine.
   output logic [7:0] rdata_out // Read data, one cycle after a read.
);
   import racs_pkg::*;
   logic [7:0] io_q [256];
   logic [7:0] xm_q [256];
   initial rdata_out = 8'h00;
   always @(posedge clk_in) begin
      // store into I/O or external memory.
      if (ext_in.wr && ext_in.mem) xm_q[ext_in.addr[7:0]] <= ext_in.wdata;
      if (ext_in.wr && !ext_in.mem) io_q[ext_in.addr[7:0]] <= ext_in.wdata;
      // fetch; an idle bus inverts its byte every cycle, so a stale byte matches only every second cycle.
      rdata_out <= ext_in.rd ? (ext_in.mem ? xm_q[ext_in.addr[7:0]] : io_q[ext_in.addr[7:0]]) : ~rdata_out;
   end
endmodule : racs_ext_model

// ===== bench/tb_top.sv
`timescale 1ns/1ns
`include "racs_params.svh"
module tb_top;
   import racs_pkg::*;
   logic clk_in, rst_n_in, order_valid_in, order_ready_out, reply_valid_out, ext_fault_in;
   racs_order_s order_in;
   racs_reply_s reply_out;
   racs_ext_s ext_out;
   racs_cfg_s cfg_out;
   logic [7:0] ext_rdata_in, v;
   logic [7:0][7:0] fn_id_in;
   logic [9:0] jumper_in;
   logic [1:0] user_led_in, led_out;
   int errors, compares;
   racs_engine #(.DIAG_SHOW_CYC(4)) i_racs_engine (.clk_in, .rst_n_in, .order_valid_in, .order_in,
      .order_ready_out, .reply_valid_out, .reply_out, .ext_out, .ext_rdata_in, .fn_id_in, .jumper_in,
      .ext_fault_in, .user_led_in, .led_out, .cfg_out);
   racs_ext_model i_racs_ext_model (.clk_in, .ext_in(ext_out), .rdata_out(ext_rdata_in));
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task end_of_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   task wait_ready;
      int i;
      for (i = 0; i < 200 && order_ready_out !== 1'b1; i++) @(negedge clk_in);
      if (i == 200) begin
         errors++;
         end_of_test;
      end
   endtask : wait_ready
   // Location i uses address a0 + as * i and data d0 + ds * i.
   task order(input logic [7:0] c, input logic [2:0] n, input logic [15:0] a0, as, input logic [7:0] d0, ds);
      int i;
      wait_ready;
      order_in.cmd = c;
      order_in.cnt = n;
      for (i = 0; i < 6; i++) begin
         order_in.addr[i] = a0 + as * 16'(i);
         order_in.data[i] = d0 + ds * 8'(i);
      end
      order_valid_in = 1'b1;
      @(negedge clk_in);
      order_valid_in = 1'b0;
      for (i = 0; i < 100 && reply_valid_out !== 1'b1; i++) @(negedge clk_in);
      if (i == 100) begin
         errors++;
         end_of_test;
      end
   endtask : order
   task t_diag;
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 100 && order_ready_out !== 1'b1; i++) begin
         if (led_out === 2'b01) seen = 1'b1;
         @(negedge clk_in);
      end
      wait_ready;
      chk("fault code", 16'h0001, seen);
      chk("node", 16'h005A, cfg_out.node);
      chk("mode", 16'h0001, cfg_out.self_clocked);
      chk("rate", RATE_62K5, cfg_out.rate);
      user_led_in = 2'b10;
      repeat (2) @(negedge clk_in);
      chk("user led", 16'h0002, led_out);
   endtask : t_diag
   task t_io;
      order(`RACS_CMD_WR_IO, 3'h2, 16'h0010, 16'h0001, 8'hC3, 8'h11);
      chk("wr status", `RACS_ST_OK, reply_out.status);
      order(`RACS_CMD_RD_IO, 3'h2, 16'h0010, 16'h0001, 8'h00, 8'h00);
      chk("rd 0", 16'h00C3, reply_out.data[0]);
      chk("rd 1", 16'h00D4, reply_out.data[1]);
      chk("rd cnt", 16'h0002, reply_out.cnt);
      order(`RACS_CMD_UPD_IO, 3'h1, 16'h0012, 16'h0000, 8'h5A, 8'h00);
      chk("upd", 16'h005A, reply_out.data[0]);
      v = 8'hC3;
      for (int k = 0; k < 3; k++) begin
         order(8'(`RACS_CMD_OR_IO + k), 3'h1, 16'h0010, 16'h0000, 8'h0F, 8'h00);
         v = (k == 0) ? (v | 8'h0F) : (k == 1) ? (v & 8'h0F) : (v ^ 8'h0F);
         chk("logic op", v, reply_out.data[0]);
      end
   endtask : t_io
   task t_mem;
      order(`RACS_CMD_WR_MEM, 3'h6, 16'h0030, 16'h0001, 8'h21, 8'h13);
      order(`RACS_CMD_RD_MEM, 3'h6, 16'h0030, 16'h0001, 8'h00, 8'h00);
      for (int i = 0; i < 6; i++) chk("ram", 8'(8'h21 + 8'h13 * i), reply_out.data[i]);
      order(`RACS_CMD_RD_MEM, 3'h2, 16'h00BF, 16'h0001, 8'h00, 8'h00);
      chk("ram range", `RACS_ST_BAD_ADDR, reply_out.status);
   endtask : t_mem
   task t_blk;
      order(`RACS_CMD_DNLOAD, 3'h3, 16'h0140, 16'h0000, 8'h71, 8'h05);
      order(`RACS_CMD_UPLOAD, 3'h3, 16'h0140, 16'h0000, 8'h00, 8'h00);
      for (int i = 0; i < 3; i++) chk("block", 8'(8'h71 + 8'h05 * i), reply_out.data[i]);
   endtask : t_blk
   task t_fn;
      order(`RACS_CMD_GET_FN, 3'h1, 16'h0000, 16'h0000, 8'h00, 8'h00);
      chk("fn cnt", 16'h0008, reply_out.cnt);
      for (int i = 0; i < 8; i++) chk("fn id", 8'(8'h80 + i), reply_out.data[i]);
   endtask : t_fn
   task t_prot;
      order(`RACS_CMD_PROTECT, 3'h1, 16'h0000, 16'h0000, 8'h01, 8'h00);
      order(`RACS_CMD_RD_IO, 3'h1, 16'h0011, 16'h0000, 8'h00, 8'h00);
      chk("suspended", `RACS_ST_PROT, reply_out.status);
      order(`RACS_CMD_PROTECT, 3'h1, 16'h0000, 16'h0000, 8'h00, 8'h00);
      order(`RACS_CMD_RD_IO, 3'h1, 16'h0011, 16'h0000, 8'h00, 8'h00);
      chk("resumed", 16'h00D4, reply_out.data[0]);
      order(`RACS_CMD_PROTECT, 3'h1, 16'h0000, 16'h0000, 8'h01, 8'h00);
      order(`RACS_CMD_RESET, 3'h1, 16'h0000, 16'h0000, 8'h00, 8'h00);
      order(`RACS_CMD_RD_IO, 3'h1, 16'h0011, 16'h0000, 8'h00, 8'h00);
      chk("after reset", `RACS_ST_OK, reply_out.status);
   endtask : t_prot
   task t_bad;
      order(8'h0D, 3'h1, 16'h0000, 16'h0000, 8'h00, 8'h00);
      chk("bad cmd", `RACS_ST_BAD_CMD, reply_out.status);
      order(`RACS_CMD_RD_IO, 3'h0, 16'h0010, 16'h0000, 8'h00, 8'h00);
      chk("cnt 0", `RACS_ST_BAD_CNT, reply_out.status);
      order(`RACS_CMD_WR_IO, 3'h7, 16'h0010, 16'h0000, 8'h00, 8'h00);
      chk("cnt 7", `RACS_ST_BAD_CNT, reply_out.status);
   endtask : t_bad
   // A second reset with synchronous mode, a set rate bit and no fault.
   task t_rst;
      logic seen;
      seen = 1'b0;
      jumper_in = {8'h3C, 1'b1, 1'b0};
      ext_fault_in = 1'b0;
      rst_n_in = 1'b0;
      repeat (4) @(negedge clk_in);
      rst_n_in = 1'b1;
      chk("led in reset", 16'h0003, led_out);
      for (int i = 0; i < 100 && order_ready_out !== 1'b1; i++) begin
         if (led_out === 2'b00) seen = 1'b1;
         @(negedge clk_in);
      end
      wait_ready;
      chk("no fault", 16'h0001, seen);
      chk("node 2", 16'h003C, cfg_out.node);
      chk("mode 2", 16'h0000, cfg_out.self_clocked);
      chk("rate 2", RATE_2400K, cfg_out.rate);
   endtask : t_rst
   initial begin
      rst_n_in = 1'b0;
      order_valid_in = 1'b0;
      order_in = '0;
      ext_fault_in = 1'b1;
      jumper_in = {8'h5A, 1'b1, 1'b1};
      user_led_in = 2'b00;
      for (int i = 0; i < 8; i++) fn_id_in[i] = 8'(8'h80 + i);
      errors = 0;
      compares = 0;
      // The clock's first step from unknown to low is a falling edge, so count rising edges.
      repeat (4) @(posedge clk_in);
      @(negedge clk_in);
      rst_n_in = 1'b1;
      t_diag;
      t_io;
      t_mem;
      t_blk;
      t_fn;
      t_prot;
      t_bad;
      t_rst;
      end_of_test;
   end
endmodule : tb_top
